/* src/asu_pkg.sv */
// Purpose: Shared constants and types for the async serial unit.
// Assumes: 32-bit AHB-Lite register access, 100 MHz hclk.
// Notes:   Offsets are byte addresses of aligned words.
`default_nettype none
package asu_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] ASU_OFF_MODE   = 8'h00;
    localparam logic [7:0] ASU_OFF_BAUD   = 8'h04;
    localparam logic [7:0] ASU_OFF_TXDATA = 8'h08;
    localparam logic [7:0] ASU_OFF_RXDATA = 8'h0C;
    localparam logic [7:0] ASU_OFF_STATUS = 8'h10;
    localparam logic [7:0] ASU_OFF_IRQ    = 8'h14;
    localparam logic [7:0] ASU_OFF_MASK   = 8'h18;
    // ==========================================================
    // Mode register fields
    localparam int ASU_B_POWER  = 7;
    localparam int ASU_B_TXEN   = 6;
    localparam int ASU_B_RXEN   = 5;
    localparam int ASU_B_PARH   = 4;
    localparam int ASU_B_PARL   = 3;
    localparam int ASU_B_CLEN   = 2;
    localparam int ASU_B_STOP   = 1;
    localparam logic [7:0] ASU_MODE_RST = 8'h01;
    localparam logic [7:0] ASU_BAUD_RST = 8'h0F;
    // Interrupt bit positions.
    localparam int ASU_IRQ_TXDONE = 0;
    localparam int ASU_IRQ_RXDONE = 1;
    localparam int ASU_IRQ_RXERR  = 2;
    localparam int ASU_IRQ_W      = 3;
    // Receiver samples a bit in the middle of 16 base clocks.
    localparam logic [3:0] ASU_OVS_LAST = 4'hF;
    localparam logic [3:0] ASU_OVS_MID  = 4'h7;
    // Synchroniser stages for enables on the base clock.
    localparam int ASU_SYNC_STAGES = 2;

    typedef struct packed {
        logic       power;
        logic       txen;
        logic       rxen;
        logic [1:0] parity;
        logic       len8;
        logic       stop2;
    } asu_ctrl_t;

    typedef struct packed {
        logic       tx_done;
        logic       rx_done;
        logic       rx_err;
        logic [7:0] rx_data;
        logic       tx_busy;
    } asu_stat_t;
endpackage : asu_pkg
`default_nettype wire

/* src/asu_rx.sv */
// Purpose: Receiver of the async serial unit.
// Assumes: base_tick is one hclk pulse per base clock; 16 ticks per bit.
// Notes:   Always one stop bit; parity and length from the mode bits.
`default_nettype none
module asu_rx
    import asu_pkg::*;
(
    // Clock and reset
    input  wire logic            hclk,
    input  wire logic            hresetn,
    input  wire logic            ce,
    // Control
    input  wire logic            base_tick,
    input  wire logic            rx_on,
    input  wire asu_pkg::asu_ctrl_t ctrl,
    input  wire logic            rxd,
    // Result
    output logic                 done,
    output logic                 err,
    output logic [7:0]           data
);
    typedef enum logic [1:0] {
        ASU_RX_IDLE  = 2'b00,
        ASU_RX_START = 2'b01,
        ASU_RX_DATA  = 2'b10,
        ASU_RX_STOP  = 2'b11
    } asu_rx_st_t;

    asu_rx_st_t st_q;
    logic [3:0] ovs_q;
    logic [3:0] bit_q;
    logic [8:0] sh_q;
    logic       pok_q;

    wire        mid     = base_tick && (ovs_q == ASU_OVS_MID);
    wire [3:0]  nbits   = ctrl.len8 ? 4'h8 : 4'h7;
    wire        par_on  = ctrl.parity[1];
    wire [3:0]  total   = nbits + {3'h0, par_on};
    // Parity: odd select when low bit set.
    wire        par_ok  = ((^sh_q) ^ ctrl.parity[0]) == 1'b0 || !par_on;
    // Received bits sit at the top of sh_q; shift them down to bit 0.
    wire [8:0]  sh_al   = sh_q >> (4'h9 - total);

    // ==========================================================
    // Receive state machine; reset when unit power or rx enable drops.
    // power clear resets
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q  <= ASU_RX_IDLE;
            ovs_q <= 4'h0;
            bit_q <= 4'h0;
            sh_q  <= 9'h000;
            done  <= 1'b0;
            err   <= 1'b0;
            data  <= 8'h00;
            pok_q <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            err  <= 1'b0;
            if (!rx_on) begin
                st_q  <= ASU_RX_IDLE;
                ovs_q <= 4'h0;
            end else if (base_tick) begin
                ovs_q <= ovs_q + 4'h1;
                case (st_q)
                    ASU_RX_IDLE: begin
                        ovs_q <= 4'h0;
                        if (!rxd) begin
                            st_q <= ASU_RX_START;
                        end
                    end
                    ASU_RX_START: begin
                        if (mid) begin
                            ovs_q <= ASU_OVS_MID + 4'h1;
                            st_q  <= rxd ? ASU_RX_IDLE : ASU_RX_DATA;
                            bit_q <= 4'h0;
                            sh_q  <= 9'h000;
                        end
                    end
                    ASU_RX_DATA: begin
                        if (mid) begin
                            sh_q  <= {rxd, sh_q[8:1]};
                            bit_q <= bit_q + 4'h1;
                            if (bit_q + 4'h1 == total) begin
                                st_q <= ASU_RX_STOP;
                            end
                        end
                    end
                    ASU_RX_STOP: begin
                        if (mid) begin
                            st_q <= ASU_RX_IDLE;
                            done <= 1'b1;
                            err  <= !rxd || !par_ok;
                            data <= ctrl.len8 ? sh_al[7:0] : {1'b0, sh_al[6:0]};
                        end
                    end
                    default: st_q <= ASU_RX_IDLE;
                endcase
            end
        end
    end
endmodule : asu_rx
`default_nettype wire

/* src/asu_top.sv */
// Purpose: Async serial unit with enable sequencing, AHB-Lite registers.
// Assumes: Single clock hclk; ce low freezes every flip-flop (clock stop).
// Notes:   Enables cross to the base clock via a tick-gated synchroniser.
//          Data writes while a frame is in flight are dropped.
//          A status read clears only the bits that it returned.
//          Parity and length apply to both directions alike.
//
// Operation
// - With clock running, the unit keeps working untouched, e.g. in halt.
// - With clock stopped, all registers freeze holding their last value.
// - With clock stopped, the transmit pin holds its last level.
// - Transmit and receive enables are synchronised on the base clock.
// - Receiver always uses one stop bit regardless of the stop setting.
`default_nettype none
module asu_top
    import asu_pkg::*;
#(
    parameter int BAUD_W = 8
) (
    // AHB-Lite slave
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Clock enable, low while the unit's clock supply is stopped
    input  wire logic        ce,
    // Serial pins
    input  wire logic        serial_receive_pin,
    output logic             serial_transmit_pin,
    // Interrupt
    output logic             irq
);
    import asu_pkg::*;

    // Elaboration check: divider and read mux serve 2 to 16 bits.
    if (BAUD_W < 2 || BAUD_W > 16) begin : g_baud_w_bad
        $error("BAUD_W out of range");
    end

    function automatic logic [31:0] asu_zx8(input logic [7:0] v);
        asu_zx8 = {24'h000000, v};
    endfunction : asu_zx8

    // ==========================================================
    // Registers and bus state
    logic [7:0]        mode_q;
    logic [BAUD_W-1:0] baud_q;
    logic [ASU_IRQ_W-1:0] irq_st_q;
    logic [ASU_IRQ_W-1:0] irq_mk_q;
    logic [7:0]        rxbuf_q;
    logic              wr_ph_q;
    logic              rd_ph_q;
    logic [7:0]        ad_q;
    logic [BAUD_W-1:0] div_q;
    logic              tick_q;
    logic [ASU_SYNC_STAGES-1:0] txs_q;
    logic [ASU_SYNC_STAGES-1:0] rxs_q;

    asu_ctrl_t ctrl;
    assign ctrl = '{power: mode_q[ASU_B_POWER], txen: mode_q[ASU_B_TXEN], rxen: mode_q[ASU_B_RXEN],
                    parity: mode_q[ASU_B_PARH:ASU_B_PARL], len8: mode_q[ASU_B_CLEN],
                    stop2: mode_q[ASU_B_STOP]};

    // Address phase capture and decode.
    wire       take      = hsel && hready && htrans[1];
    wire       tx_on     = txs_q[ASU_SYNC_STAGES-1] && ctrl.power;
    wire       rx_on     = rxs_q[ASU_SYNC_STAGES-1] && ctrl.power;
    wire       wr_mode   = wr_ph_q && ad_q == ASU_OFF_MODE;
    wire       wr_baud   = wr_ph_q && ad_q == ASU_OFF_BAUD;
    wire       wr_tx     = wr_ph_q && ad_q == ASU_OFF_TXDATA;
    wire       wr_mask   = wr_ph_q && ad_q == ASU_OFF_MASK;
    wire       rd_irq    = rd_ph_q && ad_q == ASU_OFF_IRQ;

    // ==========================================================
    // Transmitter state
    typedef enum logic [1:0] {
        ASU_TX_IDLE  = 2'b00,
        ASU_TX_SHIFT = 2'b01,
        ASU_TX_STOP  = 2'b10
    } asu_tx_st_t;
    asu_tx_st_t tx_st_q;
    logic [10:0] tx_sh_q;
    // Bit times left in the shift state; in the stop state, one less than the bit times left.
    logic [3:0]  tx_bits_q;
    logic [3:0]  tx_ovs_q;
    logic        tx_busy_q;

    wire       rx_done;
    wire       rx_err;
    wire [7:0] rx_data;
    wire       tx_done = ce && tick_q && tx_st_q == ASU_TX_STOP && tx_ovs_q == ASU_OVS_LAST
                         && tx_bits_q == 4'h0;
    wire       tx_par = ^(ctrl.len8 ? hwdata[7:0] : {1'b0, hwdata[6:0]}) ^ ctrl.parity[0];
    wire       tx_pbit = ctrl.parity[1] ? tx_par : 1'b1;
    // Frame in pin order from bit 0; spare top bits already carry stop level.
    wire [10:0] tx_frame = ctrl.len8 ? {1'b1, tx_pbit, hwdata[7:0], 1'b0}
                                     : {2'b11, tx_pbit, hwdata[6:0], 1'b0};
    wire [3:0] tx_len = (ctrl.len8 ? 4'h8 : 4'h7) + {3'h0, ctrl.parity[1]} + 4'h1;
    wire [ASU_IRQ_W-1:0] ev = {rx_err, rx_done, tx_done};
    // A read clears only what it returned: an event landing between the
    // address and data phase of that read stays set.
    wire [ASU_IRQ_W-1:0] irq_nx = (rd_irq ? irq_st_q & ~hrdata[ASU_IRQ_W-1:0] : irq_st_q) | ev;

    // ==========================================================
    // AHB-Lite data-phase tracking; slave is always ready with OKAY.
    // A data phase writes only after an accepted address phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph_q <= 1'b0;
            rd_ph_q <= 1'b0;
            ad_q    <= 8'h00;
        end else if (ce) begin
            wr_ph_q <= take && hwrite;
            rd_ph_q <= take && !hwrite;
            ad_q    <= take ? haddr : ad_q;
        end
    end

    // Read data is registered at address phase so hrdata stems from a flop.
    // Status shows the synchronised enables, not the raw mode bits.
    wire [31:0] rd_mux =
        (haddr == ASU_OFF_MODE)   ? asu_zx8(mode_q) :
        (haddr == ASU_OFF_BAUD)   ? {{(32-BAUD_W){1'b0}}, baud_q} :
        (haddr == ASU_OFF_RXDATA) ? asu_zx8(rxbuf_q) :
        (haddr == ASU_OFF_STATUS) ? {29'h0, tx_busy_q, rx_on, tx_on} :
        (haddr == ASU_OFF_IRQ)    ? {29'h0, irq_st_q} :
        (haddr == ASU_OFF_MASK)   ? {29'h0, irq_mk_q} : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (ce) begin
            hrdata    <= (take && !hwrite) ? rd_mux : hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Control registers; bit 0 of the mode register always reads one.
    // A new divider value takes effect at the next reload of the counter.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q   <= ASU_MODE_RST;
            baud_q   <= BAUD_W'(ASU_BAUD_RST);
            irq_mk_q <= '0;
        end else if (ce) begin
            if (wr_mode) mode_q   <= hwdata[7:0] | ASU_MODE_RST;
            if (wr_baud) baud_q   <= hwdata[BAUD_W-1:0];
            if (wr_mask) irq_mk_q <= hwdata[ASU_IRQ_W-1:0];
        end
    end

    // Sticky status: set beats a read-clear in the same cycle.
    // The mask gates only the output; masked events still set status.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_st_q <= '0;
            irq      <= 1'b0;
            rxbuf_q  <= 8'h00;
        end else if (ce) begin
            irq_st_q <= irq_nx;
            irq      <= |(irq_nx & irq_mk_q);
            if (rx_done) rxbuf_q <= rx_data;
        end
    end

    // ==========================================================
    // Base clock: one tick every baud_q+1 hclk cycles while powered.
    // Unpowered, the divider sits at its reload value, so the first tick
    // after power-up comes a full base-clock period later.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else if (ce) begin
            tick_q <= ctrl.power && div_q == '0;
            div_q  <= (!ctrl.power || div_q == '0) ? baud_q : div_q - 1'b1;
        end
    end

    // Enables pass two tick-gated stages; toggling one faster than two base
    // clocks may leave the stages disagreeing.
    // enable sync on base clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txs_q <= '0;
            rxs_q <= '0;
        end else if (ce) begin
            if (!ctrl.power) begin
                txs_q <= '0;
                rxs_q <= '0;
            end else if (tick_q) begin
                txs_q <= {txs_q[ASU_SYNC_STAGES-2:0], ctrl.txen};
                rxs_q <= {rxs_q[ASU_SYNC_STAGES-2:0], ctrl.rxen};
            end
        end
    end

    // ==========================================================
    // Transmitter: loads on a data write, shifts LSB first, 16 ticks a bit.
    // Each shift pulls in a one, so the line rests at stop level after the
    // payload; the stop state then counts one or two more bit times.
    // runs while ce high and tx_on set; held idle while tx_on clear, frozen while ce low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_st_q             <= ASU_TX_IDLE;
            tx_sh_q             <= 11'h7FF;
            tx_bits_q           <= 4'h0;
            tx_ovs_q            <= 4'h0;
            tx_busy_q           <= 1'b0;
            serial_transmit_pin <= 1'b1;
        end else if (ce) begin
            if (!tx_on) begin
                tx_st_q             <= ASU_TX_IDLE;
                tx_busy_q           <= 1'b0;
                serial_transmit_pin <= 1'b1;
            end else begin
                case (tx_st_q)
                    ASU_TX_IDLE: begin
                        if (wr_tx) begin
                            tx_sh_q   <= tx_frame;
                            tx_bits_q <= tx_len;
                            tx_ovs_q  <= 4'h0;
                            tx_busy_q <= 1'b1;
                            tx_st_q   <= ASU_TX_SHIFT;
                        end
                    end
                    ASU_TX_SHIFT: begin
                        serial_transmit_pin <= tx_sh_q[0];
                        if (tick_q) begin
                            tx_ovs_q <= tx_ovs_q + 4'h1;
                            if (tx_ovs_q == ASU_OVS_LAST) begin
                                tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
                                tx_bits_q <= tx_bits_q - 4'h1;
                                if (tx_bits_q == 4'h1) begin
                                    tx_st_q   <= ASU_TX_STOP;
                                    tx_bits_q <= ctrl.stop2 ? 4'h1 : 4'h0;
                                end
                            end
                        end
                    end
                    ASU_TX_STOP: begin
                        serial_transmit_pin <= 1'b1;
                        if (tick_q) begin
                            tx_ovs_q <= tx_ovs_q + 4'h1;
                            if (tx_ovs_q == ASU_OVS_LAST) begin
                                tx_bits_q <= tx_bits_q - 4'h1;
                                if (tx_bits_q == 4'h0) begin
                                    tx_st_q   <= ASU_TX_IDLE;
                                    tx_busy_q <= 1'b0;
                                end
                            end
                        end
                    end
                    default: tx_st_q <= ASU_TX_IDLE;
                endcase
            end
        end
    end

    // ==========================================================
    // Receiver; it shares the base tick.
    // Its enable is the synchronised one, gated by power.
    asu_rx u_rx (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .base_tick (tick_q),
        .rx_on     (rx_on),
        .ctrl      (ctrl),
        .rxd       (serial_receive_pin),
        .done      (rx_done),
        .err       (rx_err),
        .data      (rx_data)
    );
endmodule : asu_top
`default_nettype wire

/* verif/asu_peer.sv */
// Purpose: Remote serial peer on the far side of the pins.
// Assumes: 8 data bits, no parity, LSB first, BIT_CLKS clocks a bit.
// Notes:   The line is driven high between frames, as an idle line is.
`default_nettype none
module asu_peer #(
    parameter int BIT_CLKS = 32
) (
    // Clock
    input  wire logic hclk,
    // Serial lines
    input  wire logic tx_line,
    output logic      rx_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got_q = 8'h00;
    int         n_got = 0;
    initial rx_line = 1'b1;
    // ==========================================================
    // Decoder: mid-bit sampling; a frame with a low stop bit is not counted.
    always begin
        @(negedge tx_line);
        repeat (BIT_CLKS / 2) @(posedge hclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge hclk);
            got_q[i] = tx_line;
        end
        repeat (BIT_CLKS) @(posedge hclk);
        if (tx_line === 1'b1) begin
            n_got++;
        end
    end
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge hclk);
            rx_line <= f[i];
            repeat (BIT_CLKS - 1) @(posedge hclk);
        end
    endtask : send
endmodule : asu_peer
`default_nettype wire

/* verif/asu_properties.sv */
// Purpose: Port-level properties of the async serial unit.
// Assumes: One clock; ce low stands for a stopped clock supply.
// Notes:   Bound into asu_top below the module.
`default_nettype none
module asu_properties
    import asu_pkg::*;
#(
    parameter int BAUD_W = 8
) (
    // Bus side
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Pins
    input wire logic        ce,
    input wire logic        serial_receive_pin,
    input wire logic        serial_transmit_pin,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Helpers
    // A transfer counts only while the clock supply runs.
    wire logic take_w = hsel && hready && htrans[1] && ce;
    logic      mode_wr_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_wr_q <= 1'b0;
        end else begin
            mode_wr_q <= take_w && hwrite && (haddr == ASU_OFF_MODE);
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Data phase of a mode write that drops the power enable.
    sequence s_power_off;
        mode_wr_q && ce && !hwdata[ASU_B_POWER];
    endsequence
    // A start bit is at least eight clocks long, whatever the divider.
    sequence s_start_low;
        !serial_transmit_pin [*8];
    endsequence
    // ==========================================================
    // Properties
    // pin holds level
    a_pin_frozen: assert property (!ce |=> $stable(serial_transmit_pin))
        else $error("transmit pin moved while clock stopped");
    a_regs_frozen: assert property (!ce |=> $stable(irq) && $stable(hrdata))
        else $error("register output moved while clock stopped");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("slave stalled or answered an error");
    a_rdata_hold: assert property (!(take_w && !hwrite) |=> $stable(hrdata))
        else $error("read data changed without a read");
    a_idle_high: assert property ($rose(hresetn) |-> serial_transmit_pin)
        else $error("transmit pin not idle after reset");
    a_power_reset: assert property (s_power_off |-> ##[1:4] serial_transmit_pin)
        else $error("transmitter not idle after power enable cleared");
    a_start_width: assert property ($fell(serial_transmit_pin) |-> s_start_low)
        else $error("start bit too short");
    a_done_after_stop: assert property ($rose(irq) |-> serial_transmit_pin && $past(serial_transmit_pin, 8))
        else $error("interrupt rose before the stop bit finished");
endmodule : asu_properties
bind asu_top asu_properties #(.BAUD_W(BAUD_W)) u_asu_properties (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ce(ce), .serial_receive_pin(serial_receive_pin),
    .serial_transmit_pin(serial_transmit_pin), .irq(irq)
);
`default_nettype wire

/* verif/testbench.sv */
// Purpose: Self-checking bench for the async serial unit.
// Assumes: Baud divider 1, so a bit lasts 32 hclk cycles.
// Notes:   Bus tasks hold each phase until hready is sampled high.
`default_nettype none
module testbench;
    import asu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT_CLKS = 32;
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b0;
    logic [7:0]  haddr   = 8'h00;
    logic [1:0]  htrans  = 2'b00;
    logic        hwrite  = 1'b0;
    logic [2:0]  hsize   = 3'b010;
    logic [31:0] hwdata  = 32'h0;
    logic        ce      = 1'b1;
    wire logic        hready;
    wire logic [31:0] hrdata;
    wire logic        hreadyout;
    wire logic        hresp;
    wire logic        rx_pin;
    wire logic        tx_pin;
    wire logic        irq;
    logic [31:0] rd;
    int          error_cnt = 0;
    int          n_checks  = 0;
    // The one slave's ready is the bus ready.
    assign hready = hreadyout;
    always #5 hclk = ~hclk;
    asu_top #(.BAUD_W(8)) u_asu_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ce(ce), .serial_receive_pin(rx_pin),
        .serial_transmit_pin(tx_pin), .irq(irq)
    );
    asu_peer #(.BIT_CLKS(BIT_CLKS)) u_asu_peer (.hclk(hclk), .tx_line(tx_pin), .rx_line(rx_pin));
    // ==========================================================
    // Tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // One single transfer; read data is taken at the data-phase edge.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdc
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : wait_cyc
    task automatic done_test(input string name);
        $display("test %s finished", name);
    endtask : done_test
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    // ==========================================================
    // Watchdog: the tests need a few thousand cycles at most.
    initial begin
        repeat (20000) @(posedge hclk);
        error_cnt++;
        summarize();
    end
    // Main sequence.
    initial begin
        int n0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(ASU_OFF_MODE, {24'h0, ASU_MODE_RST});
        rdc(ASU_OFF_BAUD, {24'h0, ASU_BAUD_RST});
        rdc(8'h1C, 32'h0);
        check({31'h0, tx_pin}, 32'h1);
        done_test("reset");
        wr(ASU_OFF_BAUD, 32'h1);
        wr(ASU_OFF_MODE, 32'h85);
        wait_cyc(8);
        wr(ASU_OFF_MODE, 32'hC5);
        wait_cyc(8);
        rdc(ASU_OFF_STATUS, 32'h1);
        wr(ASU_OFF_MASK, 32'h1);
        n0 = u_asu_peer.n_got;
        wr(ASU_OFF_TXDATA, 32'hA5);
        for (int i = 0; i < 1000 && irq !== 1'b1; i++) @(posedge hclk);
        check(u_asu_peer.n_got, n0 + 1);
        check({24'h0, u_asu_peer.got_q}, 32'hA5);
        rdc(ASU_OFF_IRQ, 32'h1);
        wait_cyc(2);
        check({31'h0, irq}, 32'h0);
        done_test("transmit");
        wr(ASU_OFF_MASK, 32'h0);
        wr(ASU_OFF_TXDATA, 32'h3C);
        wait_cyc(12 * BIT_CLKS);
        check({24'h0, u_asu_peer.got_q}, 32'h3C);
        check({31'h0, irq}, 32'h0);
        rdc(ASU_OFF_IRQ, 32'h1);
        done_test("masked");
        wr(ASU_OFF_MODE, 32'h85);
        wait_cyc(8);
        wr(ASU_OFF_MODE, 32'h05);
        wr(ASU_OFF_MODE, 32'h87);
        wait_cyc(8);
        wr(ASU_OFF_MODE, 32'hA7);
        wait_cyc(8);
        wr(ASU_OFF_MASK, 32'h2);
        u_asu_peer.send(8'h5A);
        u_asu_peer.send(8'hC3);
        wait_cyc(BIT_CLKS);
        check({31'h0, irq}, 32'h1);
        rdc(ASU_OFF_IRQ, 32'h2);
        rdc(ASU_OFF_RXDATA, 32'hC3);
        done_test("receive");
        wr(ASU_OFF_MODE, 32'h87);
        wait_cyc(8);
        wr(ASU_OFF_MODE, 32'h91);
        wait_cyc(8);
        wr(ASU_OFF_MODE, 32'hF1);
        wait_cyc(8);
        u_asu_peer.send(8'hDA);
        u_asu_peer.send(8'h5A);
        wait_cyc(BIT_CLKS);
        rdc(ASU_OFF_IRQ, 32'h6);
        rdc(ASU_OFF_RXDATA, 32'h5A);
        wr(ASU_OFF_TXDATA, 32'h5A);
        wait_cyc(12 * BIT_CLKS);
        check({24'h0, u_asu_peer.got_q}, 32'h5A);
        rdc(ASU_OFF_IRQ, 32'h1);
        done_test("parity");
        wr(ASU_OFF_MODE, 32'h91);
        wait_cyc(8);
        wr(ASU_OFF_MODE, 32'h85);
        wait_cyc(8);
        wr(ASU_OFF_MODE, 32'hC5);
        wait_cyc(8);
        wr(ASU_OFF_TXDATA, 32'h0);
        wait_cyc(3 * BIT_CLKS);
        ce <= 1'b0;
        wait_cyc(50);
        check({31'h0, tx_pin}, 32'h0);
        ce <= 1'b1;
        wr(ASU_OFF_MODE, 32'h01);
        wait_cyc(4);
        check({31'h0, tx_pin}, 32'h1);
        rdc(ASU_OFF_STATUS, 32'h0);
        done_test("clock_stop");
        summarize();
    end
endmodule : testbench
`default_nettype wire
